// ---- src/lci_top.sv ----
// How it works
// - Transmitter secondary lamp flashes for ten seconds after power-up if range is reduced
// - Receiver primary lamp flashes red about 1 Hz on external fault
// - Receiver primary lamp flashes red about 10 Hz on internal error
// - Receiver primary lamp flashes green 1 Hz when outputs on, signal weak
// - Receiver secondary lamp lit when outputs off on second channel, else dark
// - Both units start on the first transmission channel
// - Units synchronize optically through two distinctly coded sync beams
// - One unobstructed sync beam suffices for sync and operation
// - Each scan walks beams first to last; scan length sets response time
// - Beams are coded so ambient steady or flickering light cannot match
// - Each channel uses its own beam codes
// - Transmitter and receiver always use the same channel
// - Reduced range wiring lowers transmitted light power
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module lci_top #(
  parameter int NUM_BEAMS     = lci_pkg::NUM_BEAMS,
  parameter int CODE_W        = lci_pkg::CODE_W,
  parameter int BIT_CYC       = lci_pkg::MOD_BIT_CYC,
  parameter int STARTUP_CYC   = lci_pkg::STARTUP_CYC,
  parameter int SLOW_HALF_CYC = lci_pkg::SLOW_HALF_CYC,
  parameter int FAST_HALF_CYC = lci_pkg::FAST_HALF_CYC
) (
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          reset_n,
  input  wire logic                          ce,
  // Register port
  input  wire logic [lci_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [lci_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [lci_pkg::DATA_W-1:0]    reg_rdata,
  output logic                               irq,
  // Unit inputs
  input  wire logic                          power_ok,
  input  wire logic                          range_reduce_wired,
  input  wire logic                          ext_fault,
  input  wire logic                          int_error,
  input  wire logic                          rx_light,
  input  wire logic                          rx_weak,
  // Optical transmit side
  output logic                               tx_emit,
  output logic      [$clog2(NUM_BEAMS)-1:0]  tx_beam_sel,
  output logic                               tx_power_low,
  // Switching outputs
  output logic                               safety_switch_output_a,
  output logic                               safety_switch_output_b,
  // Lamps
  output logic                               tx_primary_lamp_red,
  output logic                               tx_primary_lamp_green,
  output logic                               tx_secondary_lamp,
  output logic                               rx_primary_lamp_red,
  output logic                               rx_primary_lamp_green,
  output logic                               rx_secondary_lamp
);
  localparam int BW = $clog2(NUM_BEAMS);
  localparam int KW = $clog2(CODE_W);
  localparam int SW = $clog2(STARTUP_CYC + 1);

  logic [BW-1:0] beam_idx;
  logic [KW-1:0] bit_idx;
  logic          bit_tick;
  logic          beam_end;
  logic          scan_end;
  logic          slow_ph;
  logic          fast_ph;

  lci_scan #(.NUM_BEAMS(NUM_BEAMS), .CODE_W(CODE_W), .BIT_CYC(BIT_CYC)) u_scan (
    .clock    (clock),
    .reset_n  (reset_n),
    .ce       (ce),
    .beam_idx (beam_idx),
    .bit_idx  (bit_idx),
    .bit_tick (bit_tick),
    .beam_end (beam_end),
    .scan_end (scan_end)
  );

  lci_blink #(.HALF_CYC(SLOW_HALF_CYC)) u_slow (
    .clock   (clock),
    .reset_n (reset_n),
    .ce      (ce),
    .phase   (slow_ph)
  );

  lci_blink #(.HALF_CYC(FAST_HALF_CYC)) u_fast (
    .clock   (clock),
    .reset_n (reset_n),
    .ce      (ce),
    .phase   (fast_ph)
  );

  // Registers
  logic [lci_pkg::CTRL_W-1:0] ctrl_ff;
  logic [lci_pkg::IRQ_W-1:0]  irq_stat_ff;
  logic [lci_pkg::IRQ_W-1:0]  irq_mask_ff;
  logic [lci_pkg::IRQ_W-1:0]  irq_ev;
  logic [lci_pkg::ST_W-1:0]   status;
  logic [lci_pkg::DATA_W-1:0] rdata_ff;
  logic                       irq_ff;
  logic                       chan;
  logic                       dev_err;

  // One channel bit feeds both units, so they can never disagree
  assign chan    = ctrl_ff[lci_pkg::CTRL_CHAN];
  assign dev_err = ctrl_ff[lci_pkg::CTRL_DEVERR] | int_error;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= lci_pkg::CTRL_RESET;
    end else if (ce && reg_wr && reg_addr == lci_pkg::OFS_CTRL) begin
      ctrl_ff <= reg_wdata[lci_pkg::CTRL_W-1:0];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_mask_ff <= lci_pkg::IRQ_MASK_RESET;
    end else if (ce && reg_wr && reg_addr == lci_pkg::OFS_IRQ_MASK) begin
      irq_mask_ff <= reg_wdata[lci_pkg::IRQ_W-1:0];
    end
  end

  // A new event in the clearing cycle survives the write of one
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_ff <= '0;
      irq_ff      <= 1'b0;
    end else if (ce) begin
      if (reg_wr && reg_addr == lci_pkg::OFS_IRQ_STAT) begin
        irq_stat_ff <= (irq_stat_ff & ~reg_wdata[lci_pkg::IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_stat_ff <= irq_stat_ff | irq_ev;
      end
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= '0;
    end else if (ce) begin
      rdata_ff <= '0;
      if (reg_rd) begin
        case (reg_addr)
          lci_pkg::OFS_CTRL:     rdata_ff <= {30'h0000_0000, ctrl_ff};
          lci_pkg::OFS_STATUS:   rdata_ff <= {26'h000_0000, status};
          lci_pkg::OFS_IRQ_STAT: rdata_ff <= {28'h000_0000, irq_stat_ff};
          lci_pkg::OFS_IRQ_MASK: rdata_ff <= {28'h000_0000, irq_mask_ff};
          default:               rdata_ff <= '0;
        endcase
      end
    end
  end

  // Power-up window and range strap
  logic [SW-1:0] startup_cnt_ff;
  logic          startup_ff;
  logic          strap_done_ff;
  logic          range_red_ff;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      startup_cnt_ff <= '0;
      startup_ff     <= 1'b1;
    end else if (ce && startup_ff) begin
      startup_cnt_ff <= startup_cnt_ff + 1'b1;
      startup_ff     <= startup_cnt_ff != SW'(STARTUP_CYC - 1);
    end
  end

  // Wiring is read once after reset release; the reset value is a constant
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      strap_done_ff <= 1'b0;
      range_red_ff  <= 1'b0;
    end else if (ce && !strap_done_ff) begin
      strap_done_ff <= 1'b1;
      range_red_ff  <= range_reduce_wired;
    end
  end

  // Beam coding shared by both units
  lci_pkg::lci_code_kind_t kind;
  logic [CODE_W-1:0]       exp_code;
  logic [CODE_W-1:0]       rx_word;
  logic [CODE_W-1:0]       shift_ff;
  logic                    match;

  always_comb begin
    kind = lci_pkg::CODE_DATA;
    if (beam_idx == '0) begin
      kind = lci_pkg::CODE_SYNC_A;
    end else if (beam_idx == BW'(NUM_BEAMS - 1)) begin
      kind = lci_pkg::CODE_SYNC_B;
    end
  end

  assign exp_code = lci_pkg::beam_code(chan, kind);
  assign rx_word  = {shift_ff[CODE_W-2:0], rx_light};
  assign match    = rx_word == exp_code;

  // Transmitter
  logic          tx_emit_ff;
  logic [BW-1:0] tx_beam_ff;
  logic          tx_low_ff;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_emit_ff <= 1'b0;
      tx_beam_ff <= '0;
      tx_low_ff  <= 1'b0;
    end else if (ce) begin
      tx_emit_ff <= power_ok && exp_code[CODE_W - 1 - int'(bit_idx)];
      tx_beam_ff <= beam_idx;
      tx_low_ff  <= range_red_ff;
    end
  end

  // Receiver evaluation
  logic sync_a_ff;
  logic clear_ff;
  logic weak_acc_ff;
  logic weak_ff;
  logic sync_ok;

  // Sync B is the last beam, judged in the scan-end cycle itself
  assign sync_ok = sync_a_ff | match;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      shift_ff <= '0;
    end else if (ce && bit_tick) begin
      shift_ff <= rx_word;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync_a_ff <= 1'b0;
      clear_ff  <= 1'b1;
    end else if (ce && beam_end) begin
      if (scan_end) begin
        sync_a_ff <= 1'b0;
        clear_ff  <= 1'b1;
      end else if (kind == lci_pkg::CODE_SYNC_A) begin
        sync_a_ff <= match;
      end else if (!match) begin
        clear_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      weak_acc_ff <= 1'b0;
      weak_ff     <= 1'b0;
    end else if (ce && bit_tick) begin
      weak_acc_ff <= scan_end ? 1'b0 : (weak_acc_ff | rx_weak);
      if (scan_end) begin
        weak_ff <= weak_acc_ff | rx_weak;
      end
    end
  end

  lci_pkg::lci_rx_state_t st_ff;
  lci_pkg::lci_rx_state_t nxt_st;
  logic                   switch_ff;
  logic                   nxt_switch;
  logic                   fault_d_ff;

  always_comb begin
    nxt_st = st_ff;
    if (int_error) begin
      nxt_st = lci_pkg::RX_LOCK;
    end else begin
      case (st_ff)
        lci_pkg::RX_SEARCH: if (scan_end && sync_ok) nxt_st = lci_pkg::RX_RUN;
        lci_pkg::RX_RUN:    if (scan_end && !sync_ok) nxt_st = lci_pkg::RX_SEARCH;
        lci_pkg::RX_LOCK:   nxt_st = lci_pkg::RX_SEARCH;
        default:            nxt_st = lci_pkg::RX_SEARCH;
      endcase
    end
  end

  always_comb begin
    nxt_switch = switch_ff;
    if (ext_fault || int_error || !power_ok) begin
      nxt_switch = 1'b0;
    end else if (scan_end) begin
      nxt_switch = st_ff == lci_pkg::RX_RUN && sync_ok && clear_ff;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_ff      <= lci_pkg::RX_SEARCH;
      switch_ff  <= 1'b0;
      fault_d_ff <= 1'b0;
    end else if (ce) begin
      st_ff      <= nxt_st;
      switch_ff  <= nxt_switch;
      fault_d_ff <= ext_fault | int_error;
    end
  end

  always_comb begin
    irq_ev                          = '0;
    irq_ev[lci_pkg::IRQ_SWITCH_ON]  = nxt_switch && !switch_ff;
    irq_ev[lci_pkg::IRQ_SWITCH_OFF] = !nxt_switch && switch_ff;
    irq_ev[lci_pkg::IRQ_SYNC_LOST]  = st_ff == lci_pkg::RX_RUN && nxt_st != lci_pkg::RX_RUN;
    irq_ev[lci_pkg::IRQ_FAULT]      = (ext_fault | int_error) && !fault_d_ff;
  end

  always_comb begin
    status                      = '0;
    status[lci_pkg::ST_SWITCH]  = switch_ff;
    status[lci_pkg::ST_SYNC]    = st_ff == lci_pkg::RX_RUN;
    status[lci_pkg::ST_WEAK]    = weak_ff;
    status[lci_pkg::ST_RANGE]   = range_red_ff;
    status[lci_pkg::ST_STARTUP] = startup_ff;
    status[lci_pkg::ST_CHAN]    = chan;
  end

  // Lamps, all dark without power
  logic [5:0] lamp_ff;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lamp_ff <= '0;
    end else if (ce) begin
      lamp_ff <= '0;
      if (power_ok) begin
        lamp_ff[0] <= dev_err;
        lamp_ff[1] <= !dev_err;
        lamp_ff[2] <= (startup_ff && range_red_ff) ? slow_ph : chan;
        if (int_error) begin
          lamp_ff[3] <= fast_ph;
        end else if (ext_fault) begin
          lamp_ff[3] <= slow_ph;
        end else if (switch_ff) begin
          lamp_ff[4] <= weak_ff ? slow_ph : 1'b1;
        end else begin
          lamp_ff[3] <= 1'b1;
        end
        lamp_ff[5] <= !switch_ff && chan;
      end
    end
  end

  assign reg_rdata              = rdata_ff;
  assign irq                    = irq_ff;
  assign tx_emit                = tx_emit_ff;
  assign tx_beam_sel            = tx_beam_ff;
  assign tx_power_low           = tx_low_ff;
  assign safety_switch_output_a = switch_ff;
  assign safety_switch_output_b = switch_ff;
  assign tx_primary_lamp_red    = lamp_ff[0];
  assign tx_primary_lamp_green  = lamp_ff[1];
  assign tx_secondary_lamp      = lamp_ff[2];
  assign rx_primary_lamp_red    = lamp_ff[3];
  assign rx_primary_lamp_green  = lamp_ff[4];
  assign rx_secondary_lamp      = lamp_ff[5];

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  chk_tx_range_flash: assert property (
    ce && power_ok && startup_ff && range_red_ff |=> tx_secondary_lamp == $past(slow_ph))
    else $error("Range flash does not follow slow phase");
  chk_rx_ext_slow: assert property (
    ce && power_ok && ext_fault && !int_error
    |=> rx_primary_lamp_red == $past(slow_ph) && !rx_primary_lamp_green)
    else $error("External fault lamp wrong");
  chk_rx_int_fast: assert property (
    ce && power_ok && int_error |=> rx_primary_lamp_red == $past(fast_ph) && !irq_ev[0])
    else $error("Internal error lamp wrong");
  chk_rx_weak_green: assert property (
    ce && power_ok && !ext_fault && !int_error && switch_ff && weak_ff
    |=> rx_primary_lamp_green == $past(slow_ph) && !rx_primary_lamp_red)
    else $error("Weak signal lamp wrong");
  chk_rx_chan_lamp: assert property (
    ce && power_ok |=> rx_secondary_lamp == ($past(chan) && !$past(switch_ff)))
    else $error("Receiver channel lamp wrong");
  chk_chan_default: assert property (
    $rose(reset_n) |-> !chan && st_ff == lci_pkg::RX_SEARCH)
    else $error("Not on first channel after reset");
  chk_sync_one_beam: assert property (
    ce && scan_end && sync_ok && !int_error && st_ff == lci_pkg::RX_SEARCH
    |=> st_ff == lci_pkg::RX_RUN)
    else $error("Sync not taken with one free sync beam");
  chk_switch_needs_run: assert property (
    ce && !switch_ff && st_ff != lci_pkg::RX_RUN |=> !safety_switch_output_a)
    else $error("Outputs on without synchronization");
  chk_tx_power_low: assert property (
    ce && strap_done_ff && range_red_ff ##1 ce |=> tx_power_low)
    else $error("Reduced range did not lower power");
  chk_tx_error_red: assert property (
    ce && power_ok && dev_err |=> tx_primary_lamp_red && !tx_primary_lamp_green)
    else $error("Transmitter error lamp wrong");

  cov_switch_on: cover property (ce && nxt_switch && !switch_ff);
  cov_sync_found: cover property (st_ff == lci_pkg::RX_SEARCH ##1 st_ff == lci_pkg::RX_RUN);
  cov_fast_error: cover property (ce && power_ok && int_error);
endmodule : lci_top

// ---- pkg/lci_pkg.sv ----
package lci_pkg;
  // Register map, byte addresses on the plain register port
  localparam int         ADDR_W       = 4;
  localparam int         DATA_W       = 32;
  localparam logic [3:0] OFS_CTRL     = 4'h0;
  localparam logic [3:0] OFS_STATUS   = 4'h4;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
  localparam logic [3:0] OFS_IRQ_MASK = 4'hc;
  localparam int         CTRL_W       = 2;
  localparam int         CTRL_CHAN    = 0;
  localparam int         CTRL_DEVERR  = 1;
  localparam logic [1:0] CTRL_RESET   = 2'h0;
  localparam int         IRQ_W          = 4;
  localparam int         IRQ_SWITCH_ON  = 0;
  localparam int         IRQ_SWITCH_OFF = 1;
  localparam int         IRQ_SYNC_LOST  = 2;
  localparam int         IRQ_FAULT      = 3;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
  localparam int         ST_W       = 6;
  localparam int         ST_SWITCH  = 0;
  localparam int         ST_SYNC    = 1;
  localparam int         ST_WEAK    = 2;
  localparam int         ST_RANGE   = 3;
  localparam int         ST_STARTUP = 4;
  localparam int         ST_CHAN    = 5;
  // Timing
  localparam int CLK_HZ        = 40_000_000;
  localparam int STARTUP_S     = 10;
  localparam int SLOW_HZ       = 1;
  localparam int FAST_HZ       = 10;
  localparam int MOD_BIT_NS    = 1000;
  localparam int STARTUP_CYC   = CLK_HZ * STARTUP_S;
  localparam int SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_HZ);
  localparam int FAST_HALF_CYC = CLK_HZ / (2 * FAST_HZ);
  localparam int MOD_BIT_CYC   = (MOD_BIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Beam layout
  localparam int NUM_BEAMS = 16;
  localparam int CODE_W    = 8;

  typedef enum logic [1:0] {
    CODE_DATA   = 2'b00,
    CODE_SYNC_A = 2'b01,
    CODE_SYNC_B = 2'b10
  } lci_code_kind_t;

  typedef enum logic [1:0] {
    RX_SEARCH = 2'b00,
    RX_RUN    = 2'b01,
    RX_LOCK   = 2'b10
  } lci_rx_state_t;

  // Balanced words: steady light, dark and slow flicker never match
  function automatic logic [7:0] beam_code(input logic chan, input lci_code_kind_t kind);
    logic [7:0] code;
    case ({chan, kind})
      {1'b0, CODE_SYNC_A}: code = 8'h6c;
      {1'b0, CODE_SYNC_B}: code = 8'h93;
      {1'b1, CODE_DATA}:   code = 8'h96;
      {1'b1, CODE_SYNC_A}: code = 8'h35;
      {1'b1, CODE_SYNC_B}: code = 8'hca;
      default:             code = 8'h5a;
    endcase
    return code;
  endfunction : beam_code
endpackage : lci_pkg

// ---- src/lci_blink.sv ----
`timescale 1ns/1ps
module lci_blink #(
  parameter int HALF_CYC = 20_000_000
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic ce,
  // Square wave
  output logic      phase
);
  localparam int CW = $clog2(HALF_CYC + 1);

  logic [CW-1:0] cnt_ff;
  logic          phase_ff;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= '0;
    end else if (ce) begin
      cnt_ff <= (cnt_ff == CW'(HALF_CYC - 1)) ? '0 : cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase_ff <= 1'b0;
    end else if (ce && cnt_ff == CW'(HALF_CYC - 1)) begin
      phase_ff <= ~phase_ff;
    end
  end

  assign phase = phase_ff;

  chk_blink_half_bound: assert property (
    @(posedge clock) disable iff (!reset_n) cnt_ff <= CW'(HALF_CYC - 1))
    else $error("Blink counter passed its half period");
endmodule : lci_blink

// ---- src/lci_scan.sv ----
`timescale 1ns/1ps
module lci_scan #(
  parameter int NUM_BEAMS = 16,
  parameter int CODE_W    = 8,
  parameter int BIT_CYC   = 40
) (
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         reset_n,
  input  wire logic                         ce,
  // Position in the scan
  output logic [$clog2(NUM_BEAMS)-1:0]      beam_idx,
  output logic [$clog2(CODE_W)-1:0]         bit_idx,
  output logic                              bit_tick,
  output logic                              beam_end,
  output logic                              scan_end
);
  localparam int CYW = $clog2(BIT_CYC + 1);
  localparam int BW  = $clog2(NUM_BEAMS);
  localparam int KW  = $clog2(CODE_W);

  logic [CYW-1:0] cyc_ff;
  logic [KW-1:0]  bit_ff;
  logic [BW-1:0]  beam_ff;

  assign bit_tick = cyc_ff == CYW'(BIT_CYC - 1);
  assign beam_end = bit_tick && bit_ff == KW'(CODE_W - 1);
  assign scan_end = beam_end && beam_ff == BW'(NUM_BEAMS - 1);
  assign beam_idx = beam_ff;
  assign bit_idx  = bit_ff;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cyc_ff <= '0;
    end else if (ce) begin
      cyc_ff <= bit_tick ? '0 : cyc_ff + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bit_ff <= '0;
    end else if (ce && bit_tick) begin
      bit_ff <= beam_end ? '0 : bit_ff + 1'b1;
    end
  end

  // First beam to last, then wrap: one pass is one response time
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      beam_ff <= '0;
    end else if (ce && beam_end) begin
      beam_ff <= scan_end ? '0 : beam_ff + 1'b1;
    end
  end

  chk_scan_beam_order: assert property (
    @(posedge clock) disable iff (!reset_n)
    ce && beam_end && !scan_end |=> beam_ff == $past(beam_ff) + 1'b1)
    else $error("Beam index did not step by one");
endmodule : lci_scan

// ---- tb/lci_far_unit.sv ----
`timescale 1ns/1ps
module lci_far_unit #(
  parameter int NUM_BEAMS = 4
) (
  // Light from the transmitter
  input  wire logic                         tx_emit,
  input  wire logic [$clog2(NUM_BEAMS)-1:0] tx_beam_sel,
  // Obstructions and signal quality
  input  wire logic [NUM_BEAMS-1:0]         block_mask,
  input  wire logic                         weak_path,
  // Receiver front end
  output logic                              rx_light,
  output logic                              rx_weak
);
  // A blocked beam reads dark, which no balanced code word can match
  assign rx_light = tx_emit & ~block_mask[tx_beam_sel];
  assign rx_weak  = weak_path;
endmodule : lci_far_unit

// ---- tb/lci_top_tb.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module lci_top_tb;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        ce = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, power_ok = 1'b1;
  logic        range_reduce_wired = 1'b1, ext_fault = 1'b0, int_error = 1'b0;
  logic        weak_path = 1'b0;
  logic [3:0]  block_mask = 4'h0;
  logic [31:0] reg_rdata, rd;
  logic [1:0]  tx_beam_sel;
  logic        irq, rx_light, rx_weak, tx_emit, tx_power_low;
  logic        safety_switch_output_a, safety_switch_output_b;
  logic        tx_primary_lamp_red, tx_primary_lamp_green, tx_secondary_lamp;
  logic        rx_primary_lamp_red, rx_primary_lamp_green, rx_secondary_lamp;
  logic [15:0] lfsr = 16'h634f;
  int          fails = 0;
  int          cmp_count = 0;
  int          t;

  always #12.5 clock = ~clock;

  // Short counts keep the run small: a scan is 4 beams x 8 bits x 2 cycles
  lci_top #(.NUM_BEAMS(4), .CODE_W(8), .BIT_CYC(2), .STARTUP_CYC(200),
    .SLOW_HALF_CYC(8), .FAST_HALF_CYC(2)) dut (.clock, .reset_n, .ce, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .power_ok, .range_reduce_wired,
    .ext_fault, .int_error, .rx_light, .rx_weak, .tx_emit, .tx_beam_sel, .tx_power_low,
    .safety_switch_output_a, .safety_switch_output_b, .tx_primary_lamp_red,
    .tx_primary_lamp_green, .tx_secondary_lamp, .rx_primary_lamp_red,
    .rx_primary_lamp_green, .rx_secondary_lamp);

  lci_far_unit #(.NUM_BEAMS(4)) far (.tx_emit, .tx_beam_sel, .block_mask, .weak_path,
    .rx_light, .rx_weak);

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next

  function automatic logic exp_sec(input logic on, input logic chan);
    return ~on & chan;
  endfunction : exp_sec

  function automatic logic pick(input int sel);
    case (sel)
      0: return tx_secondary_lamp;
      1: return rx_primary_lamp_red;
      default: return rx_primary_lamp_green;
    endcase
  endfunction : pick

  task automatic close_out();
    if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task automatic go(input int n);
    repeat (n) @(posedge clock);
  endtask : go

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rdr

  task automatic wait_sw(input logic v, input int n);
    // Look one step past the edge so the value launched there has settled
    for (int i = 0; i < n && safety_switch_output_a !== v; i++) begin
      @(posedge clock);
      #1;
    end
    `CHK(safety_switch_output_b, v)
    if (safety_switch_output_a !== v) begin
      fails++;
      close_out();
    end
  endtask : wait_sw

  // Counts lamp edges; slow receiver lamp rates are checked within two edges of the expected count, the fast rate within four
  task automatic tog(input int sel, input int n, output int cnt);
    logic p;
    p   = pick(sel);
    cnt = 0;
    repeat (n) begin
      @(posedge clock);
      #1 if (pick(sel) !== p) cnt++;
      p = pick(sel);
    end
  endtask : tog

  task automatic do_reset(input logic rng);
    @(posedge clock);
    reset_n            <= 1'b0;
    range_reduce_wired <= rng;
    go(20);
    reset_n <= 1'b1;
  endtask : do_reset

  initial begin
    do_reset(1'b1);
    rdr(lci_pkg::OFS_STATUS, rd);
    `CHK(rd[lci_pkg::ST_STARTUP], 1'b1)
    `CHK(rd[lci_pkg::ST_RANGE], 1'b1)
    `CHK(rd[lci_pkg::ST_CHAN], 1'b0)
    `CHK(tx_power_low, 1'b1)
    rdr(lci_pkg::OFS_CTRL, rd);
    `CHK(rd, 32'h0000_0000)
    rdr(4'h1, rd);
    `CHK(rd, 32'h0000_0000)
    wr(lci_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    tog(0, 64, t);
    `CHK(t > 3, 1'b1)
    wait_sw(1'b1, 300);
    go(2);
    `CHK(irq, 1'b1)
    rdr(lci_pkg::OFS_IRQ_STAT, rd);
    `CHK(rd[lci_pkg::IRQ_SWITCH_ON], 1'b1)
    wr(lci_pkg::OFS_IRQ_STAT, 32'h0000_000f);
    go(2);
    `CHK(irq, 1'b0)
    `CHK({rx_primary_lamp_green, rx_primary_lamp_red}, 2'b10)
    `CHK({tx_primary_lamp_green, tx_primary_lamp_red}, 2'b10)
    `CHK(rx_secondary_lamp, exp_sec(1'b1, 1'b0))
    go(200);
    tog(0, 40, t);
    `CHK(t, 0)
    `CHK(tx_secondary_lamp, 1'b0)
    @(posedge clock) block_mask <= 4'b0001;
    go(192);
    `CHK(safety_switch_output_a, 1'b1)
    @(posedge clock) block_mask <= 4'b1001;
    wait_sw(1'b0, 300);
    rdr(lci_pkg::OFS_STATUS, rd);
    `CHK(rd[lci_pkg::ST_SYNC], 1'b0)
    `CHK(irq, 1'b0)
    @(posedge clock) block_mask <= 4'b0000;
    wait_sw(1'b1, 300);
    @(posedge clock) weak_path <= 1'b1;
    go(140);
    tog(2, 64, t);
    `CHK(t >= 6 && t <= 10, 1'b1)
    `CHK(rx_primary_lamp_red, 1'b0)
    @(posedge clock) weak_path <= 1'b0;
    block_mask <= 4'b0100;
    wait_sw(1'b0, 200);
    go(2);
    tog(1, 32, t);
    `CHK({t == 0, rx_primary_lamp_red}, 2'b11)
    `CHK(rx_secondary_lamp, exp_sec(1'b0, 1'b0))
    wr(lci_pkg::OFS_CTRL, 32'h0000_0001);
    go(3);
    `CHK(rx_secondary_lamp, exp_sec(1'b0, 1'b1))
    @(posedge clock) block_mask <= 4'b0000;
    wait_sw(1'b1, 400);
    go(2);
    `CHK(rx_secondary_lamp, exp_sec(1'b1, 1'b1))
    @(posedge clock) ext_fault <= 1'b1;
    wait_sw(1'b0, 3);
    go(2);
    tog(1, 64, t);
    `CHK(t >= 6 && t <= 10, 1'b1)
    @(posedge clock) ext_fault <= 1'b0;
    int_error <= 1'b1;
    go(3);
    tog(1, 64, t);
    `CHK(t >= 28 && t <= 36, 1'b1)
    `CHK(tx_primary_lamp_red, 1'b1)
    // Enable low freezes the fast flash where it stands
    @(posedge clock) ce <= 1'b0;
    go(1);
    tog(1, 16, t);
    `CHK(t, 0)
    @(posedge clock) ce <= 1'b1;
    @(posedge clock) int_error <= 1'b0;
    power_ok <= 1'b0;
    go(3);
    `CHK({tx_primary_lamp_red, tx_primary_lamp_green, tx_secondary_lamp,
      rx_primary_lamp_red, rx_primary_lamp_green, rx_secondary_lamp}, 6'h00)
    @(posedge clock) power_ok <= 1'b1;
    repeat (4) begin
      lfsr = lfsr_next(lfsr);
      wr(lci_pkg::OFS_IRQ_MASK, {16'h0000, lfsr});
      rdr(lci_pkg::OFS_IRQ_MASK, rd);
      `CHK(rd, {28'h000_0000, lfsr[3:0]})
    end
    // Write then read with no gap between the strobes
    lfsr = lfsr_next(lfsr);
    @(posedge clock) reg_addr <= lci_pkg::OFS_IRQ_MASK;
    reg_wdata <= {16'h0000, lfsr};
    reg_wr    <= 1'b1;
    @(posedge clock) reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clock) reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, {28'h000_0000, lfsr[3:0]})
    // Device error bit of the control register alone turns the lamp red
    wr(lci_pkg::OFS_CTRL, 32'h0000_0002);
    go(2);
    `CHK({tx_primary_lamp_red, tx_primary_lamp_green}, 2'b10)
    do_reset(1'b0);
    go(2);
    `CHK(tx_power_low, 1'b0)
    rdr(lci_pkg::OFS_CTRL, rd);
    `CHK(rd, 32'h0000_0000)
    tog(0, 64, t);
    `CHK(t, 0)
    close_out();
  end
endmodule : lci_top_tb
